// *** core/lpsr_pkg.sv ***
// Package with constants and types of the low-power static memory read controller
package lpsr_pkg;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 32;
	localparam int CLK_PERIOD_NS = 10;
	// Timing figures of the memory, in ns
	localparam int ADDR_TO_DATA_TIME_NS = 15;
	localparam int SELECT_TO_DATA_TIME_NS = 15;
	localparam int OE_TO_DATA_TIME_NS = 7;
	localparam int READ_CYCLE_TIME_NS = 15;
	localparam int ADDR_SETUP_NS = 0;
	localparam int SKEW_MAX_NS = 4;
	// Least times round up; only the address setup is forced to at least one cycle
	localparam int ADDR_TO_DATA_CYC =
		(ADDR_TO_DATA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SELECT_TO_DATA_CYC =
		(SELECT_TO_DATA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OE_TO_DATA_CYC =
		(OE_TO_DATA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYCLE_CYC =
		(READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_SETUP_CYC =
		(ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	// Read methods
	localparam logic [1:0] MODE_ADDR = 2'h0;
	localparam logic [1:0] MODE_SEL = 2'h1;
	localparam logic [1:0] MODE_OE = 2'h2;
	typedef enum logic [4:0] {
		LPSR_IDLE   = 5'h01,
		LPSR_SETUP  = 5'h02,
		LPSR_SELECT = 5'h04,
		LPSR_WAIT   = 5'h08,
		LPSR_DONE   = 5'h10
	} lpsr_state_e;
endpackage

// *** core/lpsr_timer.sv ***
// Down counter that times one phase of a read
`timescale 1ns/1ps
module lpsr_timer
	import lpsr_pkg::*;
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// Control
	input  wire logic             load,
	input  wire logic [CNT_W-1:0] value,
	// Status
	output logic                  expired
);
	typedef struct packed {
		logic [CNT_W-1:0] count;
	} lpsr_timer_s;

	lpsr_timer_s st;
	lpsr_timer_s next_st;

	always_comb begin
		next_st = st;
		if (load) begin
			next_st.count = value;
		end else if (st.count != '0) begin
			next_st.count = st.count - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign expired = (st.count == '0) && !load;
endmodule

// *** core/lpsr_ctrl.sv ***
// Controller that reads a low-power asynchronous static memory through its pins
`timescale 1ns/1ps
module lpsr_ctrl
	import lpsr_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// User request
	input  wire logic              req_valid,
	input  wire logic [1:0]        req_mode,
	input  wire logic [ADDR_W-1:0] req_addr,
	output logic                   req_ready,
	// User answer
	output logic                   rsp_valid,
	output logic [DATA_W-1:0]      rsp_data,
	// Memory pins
	output logic                   chip_select_n,
	output logic                   chip_select_p,
	output logic                   output_enable_low,
	output logic                   store_strobe_low,
	output logic [ADDR_W-1:0]      mem_addr,
	input  wire logic [DATA_W-1:0] mem_data_in,
	output logic [DATA_W-1:0]      mem_data_out,
	output logic                   mem_data_oe
);
	// Whole state but the timer count in one record, pins included
	typedef struct packed {
		lpsr_state_e       state;
		logic [1:0]        mode;
		logic              selected;
		logic              accessed;
		logic [ADDR_W-1:0] addr;
		logic              oe_low;
		logic              ready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [DATA_W-1:0] sync1;
		logic [DATA_W-1:0] sync2;
		logic              sel_n;
		logic              strobe_n;
		logic [DATA_W-1:0] dout;
		logic              doe;
	} lpsr_ctrl_s;

	lpsr_ctrl_s st;
	lpsr_ctrl_s next_st;

	// Timer handshake
	logic             tmr_load;
	logic [CNT_W-1:0] tmr_value;
	logic             tmr_expired;

	// Cycles to wait for data, plus the two synchroniser stages
	function automatic logic [CNT_W-1:0] lpsr_wait_cyc(input logic [1:0] mode);
		int cyc;
		cyc = ADDR_TO_DATA_CYC;
		if (mode == MODE_SEL) begin
			cyc = SELECT_TO_DATA_CYC;
		end else if (mode == MODE_OE) begin
			cyc = OE_TO_DATA_CYC;
		end
		if (cyc < READ_CYCLE_CYC) begin
			cyc = READ_CYCLE_CYC;
		end
		return CNT_W'(cyc + 2);
	endfunction

	// An address whose word was sensed and still stands on the pins needs no trigger
	function automatic logic lpsr_word_held(input lpsr_ctrl_s s,
		input logic [ADDR_W-1:0] addr);
		return s.accessed && s.selected && (s.addr == addr);
	endfunction

	// One timer serves the setup and the wait phases
	lpsr_timer u_timer (
		.clk     (clk),
		.srst    (srst),
		.load    (tmr_load),
		.value   (tmr_value),
		.expired (tmr_expired)
	);

	// Next state of everything, decided once per clock
	always_comb begin
		next_st = st;
		tmr_load = 1'b0;
		tmr_value = '0;
		// The answer stands one cycle
		next_st.rvalid = 1'b0;
		// Two flops bring the memory's data into the clock domain
		next_st.sync1 = mem_data_in;
		next_st.sync2 = st.sync1;
		unique case (st.state)
			LPSR_IDLE: begin
				if (req_valid && st.ready) begin
					next_st.ready = 1'b0;
					next_st.mode = req_mode;
					if (req_mode == MODE_OE && lpsr_word_held(st, req_addr)) begin
						// Read the word already sensed by only opening the output
						next_st.oe_low = 1'b0;
						next_st.state = LPSR_WAIT;
					end else if (req_mode == MODE_ADDR && lpsr_word_held(st, req_addr)) begin
						// Same address gives no trigger; the held word is current
						next_st.oe_low = 1'b0;
						next_st.state = LPSR_WAIT;
					end else if (req_mode == MODE_ADDR && st.selected) begin
						// Only the address moves; selects and oe stay put
						next_st.addr = req_addr;
						next_st.oe_low = 1'b0;
						next_st.state = LPSR_WAIT;
					end else begin
						// Deselect and set the new address on the same edge, with oe closed
						next_st.selected = 1'b0;
						next_st.oe_low = 1'b1;
						next_st.addr = req_addr;
						next_st.mode = MODE_SEL;
						next_st.state = LPSR_SETUP;
					end
					// Setup takes the short count, every other path the data wait
					tmr_load = 1'b1;
					tmr_value = (next_st.state == LPSR_SETUP) ? CNT_W'(ADDR_SETUP_CYC) :
						lpsr_wait_cyc(next_st.mode);
				end
			end
			LPSR_SETUP: begin
				if (tmr_expired) begin
					// Selects rise alone after the address has settled
					next_st.selected = 1'b1;
					next_st.state = LPSR_SELECT;
				end
			end

			LPSR_SELECT: begin
				// Output enable follows a cycle later, not with the selects
				next_st.oe_low = 1'b0;
				next_st.state = LPSR_WAIT;
				tmr_load = 1'b1;
				tmr_value = lpsr_wait_cyc(MODE_SEL);
			end

			LPSR_WAIT: begin
				// Address and selects hold, so only one trigger per read
				if (tmr_expired) begin
					next_st.rdata = st.sync2;
					next_st.rvalid = 1'b1;
					next_st.accessed = 1'b1;
					next_st.state = LPSR_DONE;
				end
			end

			LPSR_DONE: begin
				next_st.ready = 1'b1;
				next_st.state = LPSR_IDLE;
			end

			// Recovers from a code that is not one-hot
			default: begin
				next_st.state = LPSR_IDLE;
				next_st.ready = 1'b1;
			end
		endcase

		// Both selects come from flops of one edge, so they never skew apart
		next_st.sel_n    = ~next_st.selected;
		// Reads only: the write strobe stays high and the data bus stays released
		next_st.strobe_n = 1'b1;
		next_st.dout     = '0;
		next_st.doe      = 1'b0;
	end

	// Reset closes the output and deselects, so no read starts
	always_ff @(posedge clk) begin
		if (srst) begin
			st.state    <= LPSR_IDLE;
			st.mode     <= MODE_ADDR;
			st.selected <= 1'b0;
			st.accessed <= 1'b0;
			st.addr     <= '0;
			st.oe_low   <= 1'b1;
			st.ready    <= 1'b1;
			st.rvalid   <= 1'b0;
			st.rdata    <= '0;
			st.sync1    <= '0;
			st.sync2    <= '0;
			st.sel_n    <= 1'b1;
			st.strobe_n <= 1'b1;
			st.dout     <= '0;
			st.doe      <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// Pin outputs straight from flip-flops
	assign req_ready         = st.ready;
	assign rsp_valid         = st.rvalid;
	assign rsp_data          = st.rdata;
	assign chip_select_n     = st.sel_n;
	assign chip_select_p     = st.selected;
	assign output_enable_low = st.oe_low;
	assign store_strobe_low  = st.strobe_n;
	assign mem_addr          = st.addr;
	assign mem_data_out      = st.dout;
	assign mem_data_oe       = st.doe;
endmodule

// *** sim/lpsr_props.sv ***
// Checker of the read controller pin protocol
`timescale 1ns/1ps
module lpsr_props
	import lpsr_pkg::*;
(
	// Clock, reset and user side
	input logic              clk,
	input logic              srst,
	input logic              req_valid,
	input logic [1:0]        req_mode,
	input logic              req_ready,
	input logic              rsp_valid,
	// Memory pins
	input logic              chip_select_n,
	input logic              chip_select_p,
	input logic              output_enable_low,
	input logic              store_strobe_low,
	input logic [ADDR_W-1:0] mem_addr,
	input logic              mem_data_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_sel_walk;
		chip_select_n ##1 chip_select_n ##1 !chip_select_n && output_enable_low
			##1 !output_enable_low;
	endsequence
	sequence s_addr_walk;
		!output_enable_low && !chip_select_n ##5 rsp_valid;
	endsequence
	property p_sel;
		req_valid && req_ready && req_mode == MODE_SEL |=> s_sel_walk ##5 rsp_valid;
	endproperty
	property p_addr;
		req_valid && req_ready && req_mode == MODE_ADDR && !chip_select_n |=> s_addr_walk;
	endproperty
	property p_pair;
		chip_select_p == !chip_select_n;
	endproperty
	property p_read_only;
		store_strobe_low && !mem_data_oe;
	endproperty
	property p_setup;
		$fell(chip_select_n) |-> $stable(mem_addr);
	endproperty
	property p_settled;
		$fell(chip_select_n) |-> mem_addr == $past(mem_addr, 2);
	endproperty
	property p_one_event;
		$fell(chip_select_n) |-> output_enable_low;
	endproperty
	property p_rate;
		$changed(mem_addr) |=> $stable(mem_addr);
	endproperty
	property p_pulse;
		rsp_valid |=> !rsp_valid && req_ready;
	endproperty
	a_sel: assert property (p_sel) else $error("select read walk broken");
	a_addr: assert property (p_addr) else $error("address read walk broken");
	a_pair: assert property (p_pair) else $error("selects not paired");
	a_read_only: assert property (p_read_only) else $error("write or drive seen");
	a_setup: assert property (p_setup) else $error("address moved at select");
	a_settled: assert property (p_settled) else $error("select before address settled");
	a_one_event: assert property (p_one_event) else $error("oe with select");
	a_rate: assert property (p_rate) else $error("address changed too fast");
	a_pulse: assert property (p_pulse) else $error("answer not one pulse");
endmodule

// *** sim/lpsr_mem_model.sv ***
// Behavioural low-power static memory seen by the read controller
`timescale 1ns/1ps
module lpsr_mem_model
	import lpsr_pkg::*;
(
	// Clock of the sampling
	input logic               clk,
	// Memory pins
	input logic               chip_select_n,
	input logic               chip_select_p,
	input logic               output_enable_low,
	input logic               store_strobe_low,
	input logic [ADDR_W-1:0]  mem_addr,
	output logic [DATA_W-1:0] mem_data
);
	logic              sel;
	logic              sel_q = 1'b0;
	logic [ADDR_W-1:0] addr_q = 17'h0;
	logic [DATA_W-1:0] word = 32'h0;
	assign sel = !chip_select_n && chip_select_p;
	always @(posedge clk) begin
		sel_q <= sel;
		addr_q <= mem_addr;
		if (sel && (!sel_q || mem_addr != addr_q)) begin
			word <= {mem_addr[14:0], mem_addr};
		end
	end
	// Released bus shows the inverse of the held word
	assign mem_data = (sel && !output_enable_low && store_strobe_low) ? word : ~word;
endmodule

// *** sim/tb_lpsr_ctrl.sv ***
// Testbench of the low-power static memory read controller
`timescale 1ns/1ps
module tb_lpsr_ctrl;
	import lpsr_pkg::*;
	logic              clk = 1'b0;
	logic              srst = 1'b1;
	logic              req_valid = 1'b0;
	logic [1:0]        req_mode = MODE_ADDR;
	logic [ADDR_W-1:0] req_addr = 17'h0;
	logic              req_ready, rsp_valid, cs_n, cs_p, oe_low, ss_low, d_oe;
	logic [DATA_W-1:0] rsp_data, mem_data, d_out, bus;
	logic [ADDR_W-1:0] mem_addr;
	int                err_count = 0;
	int                check_count = 0;
	assign bus = d_oe ? d_out : mem_data;
	lpsr_ctrl lpsr_ctrl_i (.clk(clk), .srst(srst), .req_valid(req_valid), .req_mode(req_mode),
		.req_addr(req_addr), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.chip_select_n(cs_n), .chip_select_p(cs_p), .output_enable_low(oe_low),
		.store_strobe_low(ss_low), .mem_addr(mem_addr), .mem_data_in(bus),
		.mem_data_out(d_out), .mem_data_oe(d_oe));
	lpsr_mem_model lpsr_mem_model_i (.clk(clk), .chip_select_n(cs_n), .chip_select_p(cs_p),
		.output_enable_low(oe_low), .store_strobe_low(ss_low), .mem_addr(mem_addr),
		.mem_data(mem_data));
	initial begin
		forever #5 clk = ~clk;
	end
	task check(string name, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task rd(logic [1:0] m, logic [ADDR_W-1:0] a, int lat);
		int n;
		n = -1;
		req_mode <= m;
		req_addr <= a;
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		while (rsp_valid !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (n == 20) begin
			err_count++;
		end else begin
			check("latency", n, lat);
			check("data", rsp_data, {a[14:0], a});
		end
		@(posedge clk);
	endtask
	task t_reset;
		@(negedge clk);
		check("idle pins", {req_ready, cs_n, cs_p, oe_low, ss_low, d_oe}, 6'h36);
		check("idle valid", rsp_valid, '0);
		check("idle addr", mem_addr, '0);
		check("idle data", rsp_data, '0);
		check("idle drive", d_out, '0);
		@(posedge clk);
	endtask
	task t_fallback;
		rd(MODE_OE, 17'h12345, 8);
	endtask
	task t_addr;
		rd(MODE_ADDR, 17'h00000, 5);
		rd(MODE_ADDR, 17'h1ffff, 5);
		rd(MODE_ADDR, 17'h0ffff, 5);
	endtask
	task t_sel;
		rd(MODE_SEL, 17'h0ffff, 8);
		rd(MODE_SEL, 17'h10001, 8);
	endtask
	task t_oe;
		rd(MODE_OE, 17'h10001, 5);
		rd(MODE_ADDR, 17'h10001, 5);
		rd(MODE_OE, 17'h00abc, 8);
	endtask
	task t_mid_reset;
		req_mode <= MODE_SEL;
		req_addr <= 17'h0abcd;
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		repeat (2) @(posedge clk);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		t_reset;
		rd(MODE_OE, 17'h0abcd, 8);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_fallback;
		t_addr;
		t_sel;
		t_oe;
		t_mid_reset;
		end_sim;
	end
endmodule
bind lpsr_ctrl lpsr_props lpsr_props_i (.clk(clk), .srst(srst), .req_valid(req_valid),
	.req_mode(req_mode), .req_ready(req_ready), .rsp_valid(rsp_valid),
	.chip_select_n(chip_select_n), .chip_select_p(chip_select_p),
	.output_enable_low(output_enable_low), .store_strobe_low(store_strobe_low),
	.mem_addr(mem_addr), .mem_data_oe(mem_data_oe));
